// *** bench/piezo_model.sv ***
// Piezo buzzer model: measures low and high run lengths on the pin
`timescale 1ns/1ps
module piezo_model (
   input wire logic clk,
   input wire logic pin,
   output int low_len,
   output int high_len
);
   int run;
   logic last;
   initial begin
      run = 0;
      last = 1'b1;
      low_len = 0;
      high_len = 0;
   end
   // Lengths are in clk cycles, stored when the level flips
   always @(posedge clk) begin
      if (pin !== last) begin
         if (last === 1'b0) low_len <= run;
         else high_len <= run;
         run <= 1;
      end else begin
         run <= run + 1;
      end
      last <= pin;
   end
endmodule

// *** bench/test_buzzer_tone_generator.sv ***
// Self-checking bench for the buzzer tone generator
`timescale 1ns/1ps
module test_buzzer_tone_generator;
   // Oscillator sped up to 8 clk per cycle to keep the run short
   localparam int HALF = 4;
   localparam int STROBE = 128 * 2 * HALF;
   logic clk, rst, osc, cont, env_wr, env_data, env_rst, step_sel;
   logic trig, stop, len_sel, data_bit, pin, busy, env_en;
   logic [2:0] freq, level, env_level;
   int low_len, high_len, miscompares, tests_run, n, lows;
   buzzer_tone_generator DUT (.clk(clk), .rst(rst),
      .low_speed_oscillator(osc), .continuous_tone_on(cont),
      .tone_freq_select(freq), .tone_level_select(level),
      .envelope_enable_write(env_wr), .envelope_enable_data(env_data),
      .envelope_restart(env_rst), .envelope_step_time_select(step_sel),
      .single_shot_trigger(trig), .single_shot_force_stop(stop),
      .single_shot_length_select(len_sel), .shared_pin_data_bit(data_bit),
      .shared_output_pin(pin), .single_shot_busy(busy),
      .envelope_enable(env_en), .envelope_level(env_level));
   piezo_model buzzer (.clk(clk), .pin(pin), .low_len(low_len),
      .high_len(high_len));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #3;
      forever #(8 * HALF) osc = ~osc;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic give_verdict;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   initial begin
      {cont, env_wr, env_data, env_rst, step_sel, trig, stop} = 7'h00;
      {len_sel, freq, level} = 7'h00;
      miscompares = 0;
      tests_run = 0;
      data_bit = 1'b1;
      rst = 1'b1;
      tick(8);
      rst = 1'b0;
      check(pin, 1'b1);
      // Every frequency code, level code equal to it
      cont = 1'b1;
      for (int f = 0; f < 8; f++) begin
         freq = 3'(f);
         level = 3'(f);
         tick(3 * 28 * 2 * HALF + 40);
         n = (f[1] ? 12 : 8) - f;
         n = n * (f[2] ? 2 * HALF : HALF);
         check(low_len, n);
         check(low_len + high_len,
            (16 + 4 * f[1:0]) * (f[2] ? 2 * HALF : HALF));
      end
      $display("test tones done");
      cont = 1'b0;
      tick(4);
      lows = 0;
      repeat (500) begin
         tick(1);
         if (pin !== 1'b1) lows++;
      end
      check(lows, 0);
      $display("test idle done");
      // Envelope overrides a quiet level select
      freq = 3'h0;
      level = 3'h7;
      step_sel = 1'b1;
      env_wr = 1'b1;
      env_data = 1'b1;
      tick(1);
      env_wr = 1'b0;
      cont = 1'b1;
      tick(3 * 16 * HALF + 40);
      check(env_en, 1'b1);
      check(low_len, 8 * HALF);
      check(env_level, 3'h0);
      tick(16 * STROBE + STROBE / 2);
      check(env_level, 3'h1);
      step_sel = 1'b0;
      env_rst = 1'b1;
      tick(1);
      env_rst = 1'b0;
      tick(3);
      check(env_level, 3'h0);
      // Long stage time must not step where the short one would
      tick(16 * STROBE + STROBE / 2);
      check(env_level, 3'h0);
      cont = 1'b0;
      $display("test envelope done");
      // Short one-shot runs to completion
      level = 3'h3;
      len_sel = 1'b1;
      trig = 1'b1;
      tick(1);
      trig = 1'b0;
      tick(2);
      check(busy, 1'b1);
      check(env_en, 1'b0);
      n = 0;
      while (busy === 1'b1 && n < 30000) begin
         tick(1);
         n++;
      end
      check(n >= 8 * STROBE - 4 && n <= 9 * STROBE + 4, 1'b1);
      check(low_len, 5 * HALF);
      tick(2);
      check(pin, 1'b1);
      // Long one-shot outlasts the short one; forced stop cuts it
      len_sel = 1'b0;
      trig = 1'b1;
      tick(1);
      trig = 1'b0;
      tick(9 * STROBE + STROBE / 2);
      check(busy, 1'b1);
      stop = 1'b1;
      tick(1);
      stop = 1'b0;
      tick(2);
      check(busy, 1'b0);
      tick(3);
      check(pin, 1'b1);
      // Trigger ignored while continuous output is on
      cont = 1'b1;
      tick(4);
      trig = 1'b1;
      tick(1);
      trig = 1'b0;
      tick(3);
      check(busy, 1'b0);
      cont = 1'b0;
      $display("test one-shot done");
      give_verdict();
   end
   // Whole sequence needs about 59000 cycles
   initial begin
      #(100000 * 8);
      miscompares++;
      give_verdict();
   end
endmodule

// *** logic/buzzer_pkg.sv ***
// Constants shared by the buzzer tone generator files
package buzzer_pkg;
   // Low-speed oscillator in Hz; 256 Hz strobe divides it by 128
   localparam int OSC_HZ = 32768;
   localparam int STROBE_HZ = 256;
   localparam int STROBE_DIV = OSC_HZ / STROBE_HZ;
   localparam logic [6:0] STROBE_LAST = 7'(STROBE_DIV - 1);
   // Stage and one-shot times in microseconds
   localparam int ENV_STEP_LONG_US = 125000;
   localparam int ENV_STEP_SHORT_US = 62500;
   localparam int SHOT_LONG_US = 125000;
   localparam int SHOT_SHORT_US = 31250;
   // Same times as counts of 256 Hz strobes
   localparam logic [5:0] ENV_STEP_LONG_N =
      6'(ENV_STEP_LONG_US * STROBE_HZ / 1000000);
   localparam logic [5:0] ENV_STEP_SHORT_N =
      6'(ENV_STEP_SHORT_US * STROBE_HZ / 1000000);
   localparam logic [5:0] SHOT_LONG_N =
      6'(SHOT_LONG_US * STROBE_HZ / 1000000);
   localparam logic [5:0] SHOT_SHORT_N =
      6'(SHOT_SHORT_US * STROBE_HZ / 1000000);
   // Tone period in base ticks and full-level low count, by freq[1:0]
   localparam logic [4:0] PERIOD_0 = 5'h10;
   localparam logic [4:0] PERIOD_1 = 5'h14;
   localparam logic [4:0] PERIOD_2 = 5'h18;
   localparam logic [4:0] PERIOD_3 = 5'h1c;
   localparam logic [4:0] LOW_BASE_8 = 5'h08;
   localparam logic [4:0] LOW_BASE_12 = 5'h0c;
   localparam logic [2:0] LEVEL_FIRST = 3'h0;
   localparam logic [2:0] LEVEL_LAST = 3'h7;
   typedef enum {SHOT_IDLE, SHOT_WAIT, SHOT_RUN} shot_state_t;
endpackage

// *** logic/buzzer_tone_generator.sv ***
// Buzzer tone generator: divider, duty, envelope and one-shot control
// Operation
// - Continuous or one-shot drives tone ANDed with port data bit, else pin follows the bit
// - Tone divides 32.768 kHz oscillator, eight frequencies
// - Three-bit select picks 4096 to 1170.3 Hz
// - Level n gives (8-n)/16 at 4096/2048 Hz
// - Level n gives (8-n)/20 at 3276.8/1638.4
// - Level n gives (12-n)/24 or (12-n)/28
// - Duty is low time over full period
// - Active envelope overrides level select
// - Envelope starts level 0, steps, holds level 7
// - One-shot starts, stops aligned to 256 Hz
// - Force stop immediate; one-shot ignored while continuous
// - One-shot trigger clears envelope enable
`timescale 1ns/1ps
module buzzer_tone_generator (
   input wire logic clk,
   input wire logic rst,
   input wire logic low_speed_oscillator,
   input wire logic continuous_tone_on,
   input wire logic [2:0] tone_freq_select,
   input wire logic [2:0] tone_level_select,
   input wire logic envelope_enable_write,
   input wire logic envelope_enable_data,
   input wire logic envelope_restart,
   input wire logic envelope_step_time_select,
   input wire logic single_shot_trigger,
   input wire logic single_shot_force_stop,
   input wire logic single_shot_length_select,
   input wire logic shared_pin_data_bit,
   output logic shared_output_pin,
   output logic single_shot_busy,
   output logic envelope_enable,
   output logic [2:0] envelope_level
);
   logic osc_meta;
   logic osc_sync;
   logic osc_prev;
   logic tick_fast;
   logic tick_slow;
   logic tick_256;
   logic [6:0] strobe_div;
   logic [5:0] env_count;
   logic [5:0] shot_count;
   logic cont_prev;
   logic env_active;
   logic shot_on;
   logic [2:0] level;
   logic [4:0] low_base;
   buzzer_pkg::shot_state_t shot_state;
   tone_if #(.CNT_W(5)) tone();

   // Oscillator crosses in via two flops; edges taken after them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         osc_meta <= low_speed_oscillator;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   // Both edges give 65.536 kHz, rising edges 32.768 kHz
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_fast <= 1'b0;
         tick_slow <= 1'b0;
      end else begin
         tick_fast <= osc_sync ^ osc_prev;
         tick_slow <= osc_sync & !osc_prev;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_div <= 7'h00;
         tick_256 <= 1'b0;
      end else begin
         tick_256 <= tick_slow && strobe_div == buzzer_pkg::STROBE_LAST;
         if (tick_slow) begin
            strobe_div <= strobe_div + 7'h01;
         end
      end
   end

   // Frequency and duty selection
   always_comb begin
      case (tone_freq_select[1:0])
         2'h0: tone.period = buzzer_pkg::PERIOD_0;
         2'h1: tone.period = buzzer_pkg::PERIOD_1;
         2'h2: tone.period = buzzer_pkg::PERIOD_2;
         default: tone.period = buzzer_pkg::PERIOD_3;
      endcase
      low_base = tone_freq_select[1] ? buzzer_pkg::LOW_BASE_12
         : buzzer_pkg::LOW_BASE_8;
   end

   assign env_active = envelope_enable && continuous_tone_on;
   assign level = env_active ? envelope_level : tone_level_select;
   assign tone.low_count = low_base - {2'h0, level};
   assign tone.tick = tone_freq_select[2] ? tick_slow : tick_fast;
   assign tone.enable = continuous_tone_on || shot_on;

   tone_pwm #(.CNT_W(5)) u_pwm (
      .clk(clk),
      .rst(rst),
      .t(tone.gen)
   );

   // Trigger write wins over a same-cycle enable write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         envelope_enable <= 1'b0;
      end else if (single_shot_trigger) begin
         envelope_enable <= 1'b0;
      end else if (envelope_enable_write) begin
         envelope_enable <= envelope_enable_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cont_prev <= 1'b0;
      end else begin
         cont_prev <= continuous_tone_on;
      end
   end

   // Envelope steps on 256 Hz strobes, saturating at the last level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         envelope_level <= buzzer_pkg::LEVEL_FIRST;
         env_count <= 6'h00;
      end else if (!env_active || !cont_prev || envelope_restart) begin
         envelope_level <= buzzer_pkg::LEVEL_FIRST;
         env_count <= 6'h00;
      end else if (tick_256) begin
         if (env_count == (envelope_step_time_select
               ? buzzer_pkg::ENV_STEP_SHORT_N
               : buzzer_pkg::ENV_STEP_LONG_N) - 6'h01) begin
            env_count <= 6'h00;
            if (envelope_level != buzzer_pkg::LEVEL_LAST) begin
               envelope_level <= envelope_level + 3'h1;
            end
         end else begin
            env_count <= env_count + 6'h01;
         end
      end
   end

   // One-shot: wait for strobe, run a set number of strobes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shot_state <= buzzer_pkg::SHOT_IDLE;
         shot_count <= 6'h00;
      end else if (single_shot_force_stop || continuous_tone_on) begin
         shot_state <= buzzer_pkg::SHOT_IDLE;
         shot_count <= 6'h00;
      end else begin
         case (shot_state)
            buzzer_pkg::SHOT_IDLE: begin
               if (single_shot_trigger) begin
                  shot_state <= buzzer_pkg::SHOT_WAIT;
               end
            end
            buzzer_pkg::SHOT_WAIT: begin
               if (tick_256) begin
                  shot_state <= buzzer_pkg::SHOT_RUN;
                  shot_count <= 6'h00;
               end
            end
            buzzer_pkg::SHOT_RUN: begin
               if (tick_256) begin
                  if (shot_count == (single_shot_length_select
                        ? buzzer_pkg::SHOT_SHORT_N
                        : buzzer_pkg::SHOT_LONG_N) - 6'h01) begin
                     shot_state <= buzzer_pkg::SHOT_IDLE;
                  end else begin
                     shot_count <= shot_count + 6'h01;
                  end
               end
            end
            default: shot_state <= buzzer_pkg::SHOT_IDLE;
         endcase
      end
   end

   assign shot_on = shot_state == buzzer_pkg::SHOT_RUN;

   // Port bit passes through when idle; the tone only pulls it low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shared_output_pin <= 1'b1;
         single_shot_busy <= 1'b0;
      end else begin
         shared_output_pin <= tone.wave & shared_pin_data_bit;
         single_shot_busy <= shot_state != buzzer_pkg::SHOT_IDLE
            && !single_shot_force_stop && !continuous_tone_on;
      end
   end

   a_idle_pin_high: assert property (@(posedge clk) disable iff (rst)
      !tone.enable |=> shared_output_pin == $past(shared_pin_data_bit))
      else $error("pin not idle while tone off");
   a_shot_sync: assert property (@(posedge clk) disable iff (rst)
      $rose(shot_on) |-> $past(tick_256))
      else $error("one-shot start not on strobe");
   a_force_stop: assert property (@(posedge clk) disable iff (rst)
      single_shot_force_stop |=> !shot_on ##1 !single_shot_busy)
      else $error("force stop did not end one-shot");
   a_cont_blocks: assert property (@(posedge clk) disable iff (rst)
      continuous_tone_on |=> shot_state == buzzer_pkg::SHOT_IDLE)
      else $error("one-shot ran during continuous tone");
   a_trig_env_off: assert property (@(posedge clk) disable iff (rst)
      single_shot_trigger |=> !envelope_enable)
      else $error("trigger left envelope enabled");
   a_env_hold: assert property (@(posedge clk) disable iff (rst)
      env_active && cont_prev && !envelope_restart
      && envelope_level == buzzer_pkg::LEVEL_LAST
      |=> envelope_level == buzzer_pkg::LEVEL_LAST)
      else $error("envelope left its last level");
   a_env_restart: assert property (@(posedge clk) disable iff (rst)
      envelope_restart |=> envelope_level == buzzer_pkg::LEVEL_FIRST)
      else $error("envelope restart ignored");
   a_duty_select: assert property (@(posedge clk) disable iff (rst)
      !env_active |-> tone.low_count == low_base - tone_level_select)
      else $error("low count does not follow level select");
   a_env_duty: assert property (@(posedge clk) disable iff (rst)
      env_active |-> tone.low_count == low_base - envelope_level)
      else $error("envelope level not applied");
   c_shot_done: cover property (@(posedge clk) disable iff (rst)
      shot_on ##1 !shot_on);
   c_env_last: cover property (@(posedge clk) disable iff (rst)
      env_active && envelope_level == buzzer_pkg::LEVEL_LAST);
   c_cont_tone: cover property (@(posedge clk) disable iff (rst)
      continuous_tone_on && !shared_output_pin);
endmodule

// *** logic/tone_if.sv ***
// Carrier between the tone controller and the period counter
`timescale 1ns/1ps
interface tone_if #(parameter int CNT_W = 5);
   logic enable;
   logic tick;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] low_count;
   logic wave;
   modport ctrl(output enable, output tick, output period,
      output low_count, input wave);
   modport gen(input enable, input tick, input period,
      input low_count, output wave);
endinterface

// *** logic/tone_pwm.sv ***
// Tone period counter producing the low-then-high waveform
`timescale 1ns/1ps
module tone_pwm #(parameter int CNT_W = 5) (
   input wire logic clk,
   input wire logic rst,
   tone_if.gen t
);
   logic [CNT_W-1:0] count;

   generate
      if (CNT_W < 5) begin : g_width_check
         $error("tone_pwm: CNT_W must hold a 28-tick period");
      end
   endgenerate

   // Counter parks at zero so a new tone opens with its low phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (!t.enable) begin
         count <= '0;
      end else if (t.tick) begin
         if (count == t.period - 1'b1) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
      end
   end

   assign t.wave = !(t.enable && count < t.low_count);

   a_period_wrap: assert property (@(posedge clk) disable iff (rst)
      t.enable && t.tick && count == t.period - 1'b1 |=> count == 0)
      else $error("period counter did not wrap");
   a_low_first: assert property (@(posedge clk) disable iff (rst)
      t.enable && count < t.low_count |-> !t.wave)
      else $error("wave high during low phase");
   a_high_rest: assert property (@(posedge clk) disable iff (rst)
      t.enable && count >= t.low_count |-> t.wave)
      else $error("wave low during high phase");
   c_period_done: cover property (@(posedge clk) disable iff (rst)
      t.enable && t.tick && count == t.period - 1'b1);
endmodule
